// ### src/bdc_channel_bank.sv
// per-channel delay and brightness settings with registered read port
`timescale 1ns/1ps
module bdc_channel_bank
  import bdc_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire bdc_wr_type wr,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_ff,
  output logic [CHANNELS-1:0][11:0] delay_ff,
  output logic [CHANNELS-1:0][13:0] bright_ff
);
  // one delay pair and one brightness pair of byte slots per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    localparam logic [6:0] DLO = 7'(ADDR_DELAY_BASE + 2 * ch);
    localparam logic [6:0] BLO = 7'(ADDR_BRIGHT_BASE + 2 * ch);
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        delay_ff[ch] <= 12'h000;
        bright_ff[ch] <= 14'h0000;
      end else if (wr.valid) begin
        if (wr.addr == DLO) delay_ff[ch][7:0] <= wr.data;
        if (wr.addr == DLO + 7'h01) delay_ff[ch][11:8] <= wr.data[3:0];
        if (wr.addr == BLO) bright_ff[ch][7:0] <= wr.data;
        if (wr.addr == BLO + 7'h01) bright_ff[ch][13:8] <= wr.data[5:0];
      end
    end
  end

  // read mux, zero outside the bank
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= 8'h00;
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (rd_addr == 7'(ADDR_DELAY_BASE + 2 * ch)) rd_data_ff <= delay_ff[ch][7:0];
        if (rd_addr == 7'(ADDR_DELAY_BASE + 2 * ch + 1)) rd_data_ff <= {4'h0, delay_ff[ch][11:8]};
        if (rd_addr == 7'(ADDR_BRIGHT_BASE + 2 * ch)) rd_data_ff <= bright_ff[ch][7:0];
        if (rd_addr == 7'(ADDR_BRIGHT_BASE + 2 * ch + 1)) rd_data_ff <= {2'h0, bright_ff[ch][13:8]};
      end
    end
  end
endmodule : bdc_channel_bank

// ### src/bdc_dimming_control.sv
// backlight dimming control: serial registers, dimming generator, adaptive mode, decay
`timescale 1ns/1ps
// How it works
// [R1] adaptive mode: peak x1.375, duty x8/11
// [R2] adaptive entry needs all five conditions
// [R3] voltage select codes 0.6/0.8/0.4/0.5 V
// [R4] setpoint threshold at most setpoint code
// [R5] brightness threshold at most channel brightness
// [R6] adaptive mode sticks once entered
// [R7] host programs adaptive before enabling channels
// [R8] sixteen subframes filled in order
// [R9] two registers enable sixteen channels
// [R10] low code byte first, high applies
// [R11] codes above 496 use fine range
// [R12] pairing: odd channel copies even neighbour
// [R13] host sets pairing, brightness, then enables
// [R14] 12-bit delay only with vsync
// [R15] 14-bit brightness per channel
// [R16] decay disable bits for both counters
// [R17] decay interval 32 to 128 ms
// [R18] adaptive enable resets to zero
// [R19] all channel enables reset to one
// [R20] voltage flags synchronised per channel
// [R21] split thresholds compared as assembled values
module bdc_dimming_control
  import bdc_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int MS_TICKS = MS_CYCLES,
  parameter int STEP_TICKS = STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_ff,
  output logic spi_miso_oe_ff,
  input wire logic vsync,
  input wire logic [CHANNELS-1:0] channel_over,
  output logic [CHANNELS-1:0] channel_output_ff,
  output logic [10:0] peak_code_ff,
  output logic fine_range_ff,
  output logic [1:0] voltage_select_ff,
  output logic adaptive_active_ff,
  output logic [1:0] decay_pulse_ff
);
  // input synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] sclk_s_ff, cs_s_ff, mosi_s_ff, vs_s_ff;
  logic sclk_f_ff, cs_n_f_ff, mosi_f_ff, vs_f_ff;
  logic [CHANNELS-1:0] ov_s0_ff, ov_s1_ff, ov_s2_ff, ov_f_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_s_ff <= 3'h0;
      cs_s_ff <= 3'h7;
      mosi_s_ff <= 3'h0;
      vs_s_ff <= 3'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], spi_sclk};
      cs_s_ff <= {cs_s_ff[1:0], spi_cs_n};
      mosi_s_ff <= {mosi_s_ff[1:0], spi_mosi};
      vs_s_ff <= {vs_s_ff[1:0], vsync};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_f_ff <= 1'b0;
      cs_n_f_ff <= 1'b1;
      mosi_f_ff <= 1'b0;
      vs_f_ff <= 1'b0;
    end else begin
      if (sclk_s_ff[1] == sclk_s_ff[2]) sclk_f_ff <= sclk_s_ff[2];
      if (cs_s_ff[1] == cs_s_ff[2]) cs_n_f_ff <= cs_s_ff[2];
      if (mosi_s_ff[1] == mosi_s_ff[2]) mosi_f_ff <= mosi_s_ff[2];
      if (vs_s_ff[1] == vs_s_ff[2]) vs_f_ff <= vs_s_ff[2];
    end
  end

  // comparator flags per channel, same three-stage filter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ov_s0_ff <= '0;
      ov_s1_ff <= '0;
      ov_s2_ff <= '0;
      ov_f_ff <= '0;
    end else begin
      ov_s0_ff <= channel_over; // [R20]
      ov_s1_ff <= ov_s0_ff;
      ov_s2_ff <= ov_s1_ff;
      ov_f_ff <= (ov_s1_ff & ov_s2_ff) | (ov_f_ff & (ov_s1_ff | ov_s2_ff)); // [R20]
    end
  end

  logic sclk_rise, sclk_fall, vs_rise;
  assign sclk_rise = !cs_n_f_ff && (sclk_s_ff[1] == sclk_s_ff[2]) && sclk_s_ff[2] && !sclk_f_ff;
  assign sclk_fall = !cs_n_f_ff && (sclk_s_ff[1] == sclk_s_ff[2]) && !sclk_s_ff[2] && sclk_f_ff;
  assign vs_rise = (vs_s_ff[1] == vs_s_ff[2]) && vs_s_ff[2] && !vs_f_ff;

  // serial frame: shift in on rising clock, write after sixteen bits
  logic [4:0] bit_cnt_ff;
  logic [15:0] shift_in_ff;
  logic [7:0] shift_out_ff;
  logic [1:0] load_rd_ff;
  bdc_wr_type wr_ff;
  logic [7:0] reg_rd_data, bank_rd_data;
  logic [15:0] nxt_shift_in;
  assign nxt_shift_in = {shift_in_ff[14:0], mosi_f_ff};

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bit_cnt_ff <= 5'h00;
      shift_in_ff <= 16'h0000;
      wr_ff <= '0;
      load_rd_ff <= 2'b00;
    end else begin
      wr_ff.valid <= 1'b0;
      load_rd_ff <= {load_rd_ff[0], 1'b0};
      if (cs_n_f_ff) begin
        bit_cnt_ff <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_ff <= nxt_shift_in;
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == 5'(ADDR_DONE_BITS - 1)) load_rd_ff[0] <= 1'b1;
        if (bit_cnt_ff == 5'(FRAME_BITS - 1)) begin
          wr_ff.valid <= nxt_shift_in[15];
          wr_ff.addr <= nxt_shift_in[14:8];
          wr_ff.data <= nxt_shift_in[7:0];
        end
      end
    end
  end

  // read data shift out on falling clock during the data byte
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shift_out_ff <= 8'h00;
      spi_miso_ff <= 1'b0;
      spi_miso_oe_ff <= 1'b0;
    end else begin
      spi_miso_oe_ff <= !cs_n_f_ff;
      if (load_rd_ff[1]) begin
        shift_out_ff <= reg_rd_data | bank_rd_data;
      end else if (sclk_fall && bit_cnt_ff >= 5'(ADDR_DONE_BITS)) begin
        spi_miso_ff <= shift_out_ff[7];
        shift_out_ff <= {shift_out_ff[6:0], 1'b0};
      end
      if (cs_n_f_ff) spi_miso_ff <= 1'b0;
    end
  end

  // per-channel settings store
  logic [CHANNELS-1:0][11:0] delay_ff;
  logic [CHANNELS-1:0][13:0] bright_ff;
  bdc_channel_bank #(.CHANNELS(CHANNELS)) u_bank (
    .mclk(mclk),
    .nrst(nrst),
    .wr(wr_ff),
    .rd_addr(shift_in_ff[6:0]),
    .rd_data_ff(bank_rd_data),
    .delay_ff(delay_ff),
    .bright_ff(bright_ff)
  );

  // global configuration registers
  logic [15:0] enable_ff;
  logic adaptive_enable_ff, pairing_ff;
  logic [1:0] vsel_ff, decay_sel_ff;
  logic [1:0] code_low_pend_ff;
  logic [9:0] code_ff;
  logic [9:0] set_th_ff;
  logic [13:0] bri_th_ff;
  logic fb_one_off_ff, fb_two_off_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      enable_ff <= {RST_ENABLE, RST_ENABLE}; // [R19]
      adaptive_enable_ff <= 1'b0; // [R18]
      vsel_ff <= 2'b00;
      pairing_ff <= 1'b0;
      code_low_pend_ff <= 2'b00;
      code_ff <= 10'h000;
      set_th_ff <= 10'h000;
      bri_th_ff <= 14'h0000;
      fb_one_off_ff <= 1'b0;
      fb_two_off_ff <= 1'b0;
      decay_sel_ff <= 2'b00;
    end else if (wr_ff.valid) begin
      case (wr_ff.addr)
        ADDR_ENABLE_LOW: enable_ff[7:0] <= wr_ff.data; // [R9]
        ADDR_ENABLE_HIGH: enable_ff[15:8] <= wr_ff.data; // [R9]
        ADDR_ADAPTIVE: begin
          adaptive_enable_ff <= wr_ff.data[ADAPTIVE_EN_BIT];
          vsel_ff <= wr_ff.data[VSEL_LSB +: 2];
        end
        ADDR_CODE_LOW: code_low_pend_ff <= wr_ff.data[1:0]; // [R10]
        ADDR_CODE_HIGH: code_ff <= {wr_ff.data, code_low_pend_ff}; // [R10]
        ADDR_PAIRING: pairing_ff <= wr_ff.data[PAIRING_BIT];
        ADDR_DECAY: begin
          fb_two_off_ff <= wr_ff.data[FB_TWO_DECAY_OFF_BIT]; // [R16]
          fb_one_off_ff <= wr_ff.data[FB_ONE_DECAY_OFF_BIT]; // [R16]
          decay_sel_ff <= wr_ff.data[DECAY_SEL_LSB +: 2];
        end
        ADDR_SET_TH_HIGH: set_th_ff[9:2] <= wr_ff.data;
        ADDR_SET_TH_LOW: set_th_ff[1:0] <= wr_ff.data[1:0];
        ADDR_BRI_TH_LOW: bri_th_ff[7:0] <= wr_ff.data;
        ADDR_BRI_TH_HIGH: bri_th_ff[13:8] <= wr_ff.data[5:0];
        default: ;
      endcase
    end
  end

  // register read mux for the global registers
  always_comb begin
    case (shift_in_ff[6:0])
      ADDR_ENABLE_LOW: reg_rd_data = enable_ff[7:0];
      ADDR_ENABLE_HIGH: reg_rd_data = enable_ff[15:8];
      ADDR_ADAPTIVE: reg_rd_data = {adaptive_enable_ff, 1'b0, vsel_ff, 3'b000, adaptive_active_ff};
      ADDR_CODE_HIGH: reg_rd_data = code_ff[9:2];
      ADDR_CODE_LOW: reg_rd_data = {6'h00, code_ff[1:0]};
      ADDR_PAIRING: reg_rd_data = {pairing_ff, 7'h00};
      ADDR_DECAY: reg_rd_data = {fb_two_off_ff, fb_one_off_ff, 4'h0, decay_sel_ff};
      ADDR_SET_TH_HIGH: reg_rd_data = set_th_ff[9:2];
      ADDR_SET_TH_LOW: reg_rd_data = {6'h00, set_th_ff[1:0]};
      ADDR_BRI_TH_LOW: reg_rd_data = bri_th_ff[7:0];
      ADDR_BRI_TH_HIGH: reg_rd_data = {2'h0, bri_th_ff[13:8]};
      default: reg_rd_data = 8'h00;
    endcase
  end

  // step divider and frame position; vsync restarts the dimming cycle
  logic [15:0] div_ff;
  logic step_en_ff;
  logic [POS_BITS-1:0] pos_ff;
  logic vs_present_ff;
  logic [POS_BITS:0] vs_miss_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_ff <= 16'h0000;
      step_en_ff <= 1'b0;
    end else begin
      step_en_ff <= (div_ff == 16'(STEP_TICKS - 1));
      div_ff <= (div_ff == 16'(STEP_TICKS - 1)) ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pos_ff <= '0;
    end else if (vs_rise) begin
      pos_ff <= '0;
    end else if (step_en_ff) begin
      pos_ff <= pos_ff + 1'b1;
    end
  end

  // vsync present while edges keep arriving within two dimming cycles
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      vs_present_ff <= 1'b0;
      vs_miss_ff <= '0;
    end else if (vs_rise) begin
      vs_present_ff <= 1'b1;
      vs_miss_ff <= '0;
    end else if (step_en_ff) begin
      if (&vs_miss_ff) vs_present_ff <= 1'b0;
      else vs_miss_ff <= vs_miss_ff + 1'b1;
    end
  end

  // adaptive entry: all five conditions, then held until reset
  logic any_over, any_bright;
  always_comb begin
    any_over = 1'b0;
    any_bright = 1'b0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      any_over = any_over | (ov_f_ff[ch] & enable_ff[ch]);
      any_bright = any_bright | (enable_ff[ch] & (bri_th_ff <= bright_ff[ch])); // [R5] [R21]
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      adaptive_active_ff <= 1'b0;
    end else if (adaptive_enable_ff && any_over && (set_th_ff <= code_ff) // [R2] [R4] [R21]
                 && any_bright && vs_present_ff) begin // [R2]
      adaptive_active_ff <= 1'b1; // [R6]
    end
  end

  // analog-facing levels: threshold select, range and peak code
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      voltage_select_ff <= 2'b00;
      fine_range_ff <= 1'b0;
      peak_code_ff <= 11'h000;
    end else begin
      voltage_select_ff <= vsel_ff; // [R3]
      fine_range_ff <= (code_ff > LOW_RANGE_LAST); // [R11]
      if (adaptive_active_ff)
        peak_code_ff <= {1'b0, code_ff} + {3'b000, code_ff[9:2]} + {4'h0, code_ff[9:3]}; // [R1]
      else
        peak_code_ff <= {1'b0, code_ff};
    end
  end

  // per-channel dimming: equal share per subframe, remainder filled in subframe order
  logic [CHANNELS-1:0] dim_on;
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_dim
    logic [23:0] scaled;
    logic [13:0] eff;
    logic [POS_BITS-1:0] dpos;
    logic [STEP_BITS:0] share;
    assign scaled = bright_ff[ch] * DUTY_SCALE;
    assign eff = adaptive_active_ff ? scaled[23:10] : bright_ff[ch]; // [R1] [R15]
    assign dpos = vs_present_ff ? pos_ff - {delay_ff[ch], 2'b00} : pos_ff; // [R14]
    assign share = {1'b0, eff[13:4]} + {10'h000, (dpos[13:10] < eff[3:0])}; // [R8]
    assign dim_on[ch] = {1'b0, dpos[STEP_BITS-1:0]} < share; // [R8]
  end

  // channel outputs with pairing and drive enables
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      channel_output_ff <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (pairing_ff && ch[0])
          channel_output_ff[ch] <= dim_on[ch - 1] & enable_ff[ch]; // [R12]
        else
          channel_output_ff[ch] <= dim_on[ch] & enable_ff[ch]; // [R9]
      end
    end
  end

  // decay interval: millisecond prescaler and 32 ms granularity counter
  logic [16:0] ms_div_ff;
  logic [6:0] ms_cnt_ff;
  logic [6:0] decay_ms;
  assign decay_ms = 7'(DECAY_MIN_MS * (decay_sel_ff + 1) - 1); // [R17]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ms_div_ff <= '0;
      ms_cnt_ff <= '0;
      decay_pulse_ff <= 2'b00;
    end else begin
      decay_pulse_ff <= 2'b00;
      if (ms_div_ff == 17'(MS_TICKS - 1)) begin
        ms_div_ff <= '0;
        if (ms_cnt_ff >= decay_ms) begin
          ms_cnt_ff <= '0;
          decay_pulse_ff <= {!fb_two_off_ff, !fb_one_off_ff}; // [R16] [R17]
        end else begin
          ms_cnt_ff <= ms_cnt_ff + 7'h01;
        end
      end else begin
        ms_div_ff <= ms_div_ff + 17'h00001;
      end
    end
  end
endmodule : bdc_dimming_control

// ### src/bdc_pkg.sv
// shared constants and types of the backlight dimming control block
package bdc_pkg;
  // register offsets
  localparam logic [6:0] ADDR_ENABLE_LOW = 7'h01;
  localparam logic [6:0] ADDR_ENABLE_HIGH = 7'h02;
  localparam logic [6:0] ADDR_ADAPTIVE = 7'h07;
  localparam logic [6:0] ADDR_CODE_HIGH = 7'h0c;
  localparam logic [6:0] ADDR_CODE_LOW = 7'h0d;
  localparam logic [6:0] ADDR_PAIRING = 7'h13;
  localparam logic [6:0] ADDR_DELAY_BASE = 7'h16;
  localparam logic [6:0] ADDR_DELAY_LAST = 7'h35;
  localparam logic [6:0] ADDR_BRIGHT_BASE = 7'h37;
  localparam logic [6:0] ADDR_BRIGHT_LAST = 7'h56;
  localparam logic [6:0] ADDR_DECAY = 7'h66;
  localparam logic [6:0] ADDR_SET_TH_HIGH = 7'h6d;
  localparam logic [6:0] ADDR_SET_TH_LOW = 7'h6e;
  localparam logic [6:0] ADDR_BRI_TH_LOW = 7'h6f;
  localparam logic [6:0] ADDR_BRI_TH_HIGH = 7'h70;
  // field positions
  localparam int ADAPTIVE_EN_BIT = 7;
  localparam int VSEL_LSB = 4;
  localparam int ADAPTIVE_STATE_BIT = 0;
  localparam int PAIRING_BIT = 7;
  localparam int FB_TWO_DECAY_OFF_BIT = 7;
  localparam int FB_ONE_DECAY_OFF_BIT = 6;
  localparam int DECAY_SEL_LSB = 0;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // setpoint range boundary: codes above this use the fine range
  localparam logic [9:0] LOW_RANGE_LAST = 10'h1f0;
  // dimming geometry: 16 subframes of 1024 steps
  localparam int SUBFRAMES = 16;
  localparam int SUB_BITS = 4;
  localparam int STEP_BITS = 10;
  localparam int POS_BITS = SUB_BITS + STEP_BITS;
  // adaptive duty scale 8/11 as 745/1024
  localparam logic [9:0] DUTY_SCALE = 10'h2e9;
  // timing
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int DECAY_MIN_MS = 32;
  localparam int DECAY_MAX_MS = 128;
  localparam int FRAME_US = 16667;
  localparam int STEP_CYCLES = (FRAME_US * 1000 / CLK_NS) / (SUBFRAMES * 1024);
  // serial frame layout: write flag, 7-bit address, 8-bit data
  localparam int FRAME_BITS = 16;
  localparam int ADDR_DONE_BITS = 8;
  // one register write carried as a unit
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } bdc_wr_type;
endpackage : bdc_pkg

// ### test/bdc_dimming_sva.sv
// port checker for the backlight dimming control block
`timescale 1ns/1ps
module bdc_dimming_sva
  import bdc_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_ff,
  input wire logic vsync,
  input wire logic [CHANNELS-1:0] channel_over,
  input wire logic [10:0] peak_code_ff,
  input wire logic fine_range_ff,
  input wire logic adaptive_active_ff,
  input wire logic [1:0] decay_pulse_ff
);
  logic seen_vsync_ff;
  logic pulsed_ff;
  logic [10:0] base_ff;
  int gap_ff;
  logic any_over;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // vsync seen, peak code before adaptive entry, cycles since last decay pulse
  assign any_over = |channel_over;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seen_vsync_ff <= 1'b0;
    end else if (vsync) begin
      seen_vsync_ff <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!adaptive_active_ff) begin
      base_ff <= peak_code_ff;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gap_ff <= 0;
      pulsed_ff <= 1'b0;
    end else if (decay_pulse_ff[0]) begin
      gap_ff <= 0;
      pulsed_ff <= 1'b1;
    end else if (gap_ff < 32'h0fff_ffff) begin
      gap_ff <= gap_ff + 1;
    end
  end

  property p_peak_scale;
    adaptive_active_ff && $past(adaptive_active_ff, 3) |->
      peak_code_ff == base_ff + (base_ff >> 2) + (base_ff >> 3);
  endproperty
  a_peak_scale: assert property (p_peak_scale)
    else $error("adaptive peak code wrong");
  property p_entry_vsync;
    $rose(adaptive_active_ff) |-> seen_vsync_ff;
  endproperty
  a_entry_vsync: assert property (p_entry_vsync)
    else $error("adaptive entry without vsync");
  property p_entry_over;
    $rose(adaptive_active_ff) |-> $past(any_over, 2);
  endproperty
  a_entry_over: assert property (p_entry_over)
    else $error("adaptive entry without voltage flag");
  property p_sticky;
    adaptive_active_ff |=> adaptive_active_ff;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("adaptive mode dropped");
  property p_rst_clear;
    disable iff (1'b0) !nrst |=> !adaptive_active_ff && peak_code_ff == 11'h000;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset left adaptive state");
  property p_fine;
    !adaptive_active_ff && $stable(peak_code_ff) && $past(peak_code_ff, 2) == peak_code_ff
      |-> fine_range_ff == (peak_code_ff > 11'h1f0);
  endproperty
  a_fine: assert property (p_fine)
    else $error("range select wrong");
  property p_oe;
    $fell(spi_cs_n) |-> ##[1:6] spi_miso_oe_ff;
  endproperty
  a_oe: assert property (p_oe)
    else $error("serial output not enabled");
  property p_gap;
    decay_pulse_ff[0] && pulsed_ff |-> gap_ff >= 32 * MS_TICKS - 1;
  endproperty
  a_gap: assert property (p_gap)
    else $error("decay interval too short");
  property p_width;
    decay_pulse_ff[1] |=> !decay_pulse_ff[1];
  endproperty
  a_width: assert property (p_width)
    else $error("decay pulse too long");

  c_enter: cover property ($rose(adaptive_active_ff));
  c_decay: cover property (decay_pulse_ff[0]);
  c_frame: cover property ($fell(spi_cs_n));
endmodule : bdc_dimming_sva

bind bdc_dimming_control bdc_dimming_sva #(.CHANNELS(CHANNELS), .MS_TICKS(MS_TICKS))
  bdc_dimming_sva_i (
  .mclk(mclk),
  .nrst(nrst),
  .spi_cs_n(spi_cs_n),
  .spi_miso_oe_ff(spi_miso_oe_ff),
  .vsync(vsync),
  .channel_over(channel_over),
  .peak_code_ff(peak_code_ff),
  .fine_range_ff(fine_range_ff),
  .adaptive_active_ff(adaptive_active_ff),
  .decay_pulse_ff(decay_pulse_ff)
);

// ### test/bdc_spi_host.sv
// host serial master model that writes and reads device registers
`timescale 1ns/1ps
module bdc_spi_host (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso_ff,
  input wire logic spi_miso_oe_ff
);
  // idle levels: clock low, select released
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // wait n falling edges of the system clock
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // one 16-bit frame, mode 0, msb first; half period of 10 system clocks
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rdata);
    rdata = 8'h00;
    idle(1);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = frame[i];
      idle(10);
      if (i < 8) begin
        rdata = {rdata[6:0], spi_miso_oe_ff ? spi_miso_ff : 1'b0};
      end
      spi_sclk = 1'b1;
      idle(10);
      spi_sclk = 1'b0;
    end
    idle(10);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale value
    idle(12);
  endtask : xfer
endmodule : bdc_spi_host

// ### test/tb.sv
// self-checking bench for the backlight dimming control block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module tb;
  import bdc_pkg::*;
  localparam int MS_T = 10;
  localparam int ST_T = 1; // one step per clock keeps full-period watches short
  localparam int PERIOD = SUBFRAMES * 1024 * ST_T;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic vsync = 1'b0;
  logic [15:0] channel_over = 16'h0000;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso_ff;
  logic spi_miso_oe_ff;
  logic [15:0] chan;
  logic [10:0] peak;
  logic fine;
  logic [1:0] vsel;
  logic adapt;
  logic [1:0] decay;
  int mismatches = 0;
  int n_tests = 0;
  int cnt [5];
  logic [9:0] codes [3] = '{10'h1f0, 10'h1f1, 10'h001};
  logic [6:0] ra [6] = '{ADDR_ENABLE_LOW, ADDR_ENABLE_HIGH, ADDR_PAIRING, ADDR_DECAY,
                         ADDR_SET_TH_HIGH, ADDR_BRI_TH_HIGH};
  logic [7:0] rv [6] = '{8'ha5, 8'h5a, 8'h80, 8'hc3, 8'h7c, 8'h3f};

  // 100 MHz system clock
  always #5 mclk = ~mclk;

  bdc_dimming_control #(.MS_TICKS(MS_T), .STEP_TICKS(ST_T)) bdc_dimming_control_i (
    .mclk(mclk),
    .nrst(nrst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_ff(spi_miso_ff),
    .spi_miso_oe_ff(spi_miso_oe_ff),
    .vsync(vsync),
    .channel_over(channel_over),
    .channel_output_ff(chan),
    .peak_code_ff(peak),
    .fine_range_ff(fine),
    .voltage_select_ff(vsel),
    .adaptive_active_ff(adapt),
    .decay_pulse_ff(decay)
  );
  bdc_spi_host bdc_spi_host_i (
    .mclk(mclk),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_ff(spi_miso_ff),
    .spi_miso_oe_ff(spi_miso_oe_ff)
  );

  // register access and observation helpers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    bdc_spi_host_i.xfer({1'b1, a, d}, r);
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    bdc_spi_host_i.xfer({1'b0, a, 8'h00}, d);
    `CHK(d, e)
  endtask : rc
  task automatic watch(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge mclk);
      cnt[0] += chan[0];
      cnt[1] += chan[1];
      cnt[2] += chan[0] ^ chan[1];
      cnt[3] += decay[0];
      cnt[4] += decay[1];
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    logic [10:0] prev;
    prev = 11'h000;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    watch(4);
    rc(ADDR_ENABLE_LOW, RST_ENABLE);
    rc(ADDR_ENABLE_HIGH, RST_ENABLE);
    rc(ADDR_ADAPTIVE, RST_ZERO);
    wr(7'h7f, 8'ha5);
    rc(7'h7f, RST_ZERO);
    foreach (ra[i]) begin
      wr(ra[i], rv[i]);
      rc(ra[i], rv[i]);
    end
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_ADAPTIVE, 8'(v << VSEL_LSB));
      watch(2);
      `CHK(vsel, 2'(v))
    end
    $display("test registers done");
    foreach (codes[i]) begin
      wr(ADDR_CODE_LOW, {6'h00, codes[i][1:0]});
      `CHK(peak, prev)
      wr(ADDR_CODE_HIGH, codes[i][9:2]);
      prev = {1'b0, codes[i]};
      `CHK(peak, prev)
      `CHK(fine, codes[i] > 10'h1f0)
    end
    $display("test setpoint done");
    wr(ADDR_PAIRING, RST_ZERO);
    wr(ADDR_BRIGHT_BASE, 8'h35);
    wr(ADDR_BRIGHT_BASE + 7'h01, 8'h12);
    wr(ADDR_ENABLE_LOW, 8'h03);
    watch(PERIOD);
    `CHK(cnt[0], 32'h1235 * ST_T)
    `CHK(cnt[1], 0)
    wr(ADDR_PAIRING, 8'h80);
    watch(PERIOD);
    `CHK(cnt[2], 0)
    `CHK(cnt[1], 32'h1235 * ST_T)
    wr(ADDR_ENABLE_LOW, 8'h02);
    watch(64);
    `CHK(cnt[0], 0)
    // channel 1 gets the same brightness and a one-subframe delay
    wr(ADDR_PAIRING, RST_ZERO);
    wr(ADDR_BRIGHT_BASE + 7'h02, 8'h35);
    wr(ADDR_BRIGHT_BASE + 7'h03, 8'h12);
    wr(ADDR_DELAY_BASE + 7'h03, 8'h01);
    wr(ADDR_ENABLE_LOW, 8'h03);
    // without vsync the delay is ignored, so both channels match
    watch(PERIOD);
    `CHK(cnt[2], 0)
    vsync = 1'b1;
    watch(20);
    vsync = 1'b0;
    // with vsync the shifted pattern differs in subframes 0 and 5 by one step each
    watch(PERIOD);
    `CHK(cnt[2], 2 * ST_T)
    $display("test dimming done");
    wr(ADDR_DECAY, 8'h01);
    watch(700);
    watch(1280);
    `CHK(cnt[3], 2)
    `CHK(cnt[4], 2)
    wr(ADDR_DECAY, 8'h81);
    watch(700);
    watch(1280);
    `CHK(cnt[4], 0)
    `CHK(cnt[3], 2)
    $display("test decay done");
    wr(ADDR_ENABLE_LOW, RST_ZERO);
    wr(ADDR_CODE_LOW, 8'h01);
    wr(ADDR_CODE_HIGH, 8'h7c);
    wr(ADDR_SET_TH_LOW, 8'h01);
    wr(ADDR_BRI_TH_LOW, 8'h36);
    wr(ADDR_BRI_TH_HIGH, 8'h12);
    wr(ADDR_ADAPTIVE, 8'h80);
    channel_over = 16'hffff;
    vsync = 1'b1;
    watch(20);
    vsync = 1'b0;
    wr(ADDR_ENABLE_LOW, 8'h01);
    watch(50);
    `CHK(adapt, 1'b0)
    wr(ADDR_SET_TH_LOW, 8'h02);
    wr(ADDR_BRI_TH_LOW, 8'h35);
    watch(50);
    `CHK(adapt, 1'b0)
    wr(ADDR_SET_TH_LOW, 8'h01);
    for (int i = 0; i < 500 && adapt !== 1'b1; i++) @(negedge mclk);
    if (adapt !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    watch(8);
    `CHK(peak, 11'h2ab)
    rc(ADDR_ADAPTIVE, 8'h81);
    wr(ADDR_ADAPTIVE, RST_ZERO);
    channel_over = 16'h0000;
    watch(50);
    `CHK(adapt, 1'b1)
    $display("test adaptive done");
    tally_and_finish();
  end
endmodule : tb
